/* File: hw/homing_cfg.svh */
// register offsets, field positions, reset values and timing counts for the homing search block
`ifndef HOMING_CFG_SVH
`define HOMING_CFG_SVH

`define CLK_PERIOD_NS     25
`define SAMPLE_PERIOD_US  500
`define SAMPLE_CYCLES     ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define DEBOUNCE_MAX_MS   20
`define WINDOW_MAX        ((`DEBOUNCE_MAX_MS * 1000) / `SAMPLE_PERIOD_US)

`define OFF_CONFIG        12'h000
`define OFF_CONTROL       12'h004
`define OFF_STATUS        12'h008
`define OFF_HOME_POS      12'h00C
`define OFF_POSITION      12'h010

`define CFG_MODE_LSB      0
`define CFG_DEB_LSB       8
`define CFG_INV_HOME      16
`define CFG_INV_ENDP      17
`define CFG_INV_ENDN      18
`define CFG_SWAP_END      19
`define CFG_NO_ZERO_MOVE  20
`define CFG_RESET         32'h0000_0013

`define CTL_START         0
`define CTL_ABORT         1

`define MODE_19           8'h13
`define MODE_20           8'h14
`define MODE_21           8'h15
`define MODE_22           8'h16

`endif

/* File: hw/homing_pkg.sv */
// types shared by the homing search block
package homing_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SEEK  = 4'b0010,
		ST_ZERO  = 4'b0100,
		ST_DONE  = 4'b1000
	} home_state_type;

	typedef struct packed {
		logic home;
		logic end_pos;
		logic end_neg;
	} switch_type;

	typedef struct packed {
		logic run;
		logic dir_pos;
		logic move_to_zero;
		logic limits_off;
	} motion_type;
endpackage

/* File: hw/homing_switch_edge_search.sv */
// homing switch conditioning and edge search with apb registers
`timescale 1ns/10ps
`include "homing_cfg.svh"
// Functional notes
// - sample home switch every half millisecond
// - debounce home switch by majority vote
// - flip state when over half samples differ
// - window length from debounce time 0-20ms
// - zero debounce time passes samples directly
// - optional inversion forms switch logic states
// - end switch side assignment may swap
// - modes 19/20 switch active positive side
// - modes 19/20 inactive start searches positive
// - modes 21/22 active negative, inactive start searches negative
// - modes 19/21 latch on falling edge
// - modes 20/22 latch on rising edge
// - motor zero pulse ignored in these modes
// - move to zero after capture, suppressible
// - software end limits off during homing
module homing_switch_edge_search (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// switch inputs and axis feedback
	input  wire homing_pkg::switch_type switch_raw,
	input  wire logic                 zero_pulse,
	input  wire logic [31:0]          axis_position,
	input  wire logic                 zero_reached,
	// motion and switch logic states
	output homing_pkg::motion_type    motion,
	output homing_pkg::switch_type    switch_logic,
	output logic                      home_valid
);
	import homing_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [31:0]          config_reg;
	logic [31:0]          home_pos;
	logic [15:0]          tick_cnt;
	logic [`WINDOW_MAX-1:0] sample_hist;
	logic [5:0]           sample_fill;
	logic                 home_deb;
	home_state_type       state;
	home_state_type       next_state;
	logic [31:0]          next_prdata;

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [5:0] window_len(input logic [7:0] deb_ms);
		logic [7:0] ms;
		ms = (deb_ms > 8'(`DEBOUNCE_MAX_MS)) ? 8'(`DEBOUNCE_MAX_MS) : deb_ms;
		window_len = 6'(ms * 8'(1000 / `SAMPLE_PERIOD_US));
	endfunction

	function automatic logic [5:0] count_ones(input logic [`WINDOW_MAX-1:0] v, input logic [5:0] n);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < `WINDOW_MAX; i++) begin
			if (6'(i) < n && v[i])
				c = c + 6'h01;
		end
		count_ones = c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// decode
	wire        setup_wr    = psel && !penable && pwrite;
	wire        access      = psel && penable;
	wire        wr_cfg      = access && pwrite && paddr == `OFF_CONFIG;
	wire        wr_ctl      = access && pwrite && paddr == `OFF_CONTROL;
	wire        start_req   = wr_ctl && pwdata[`CTL_START] && state != ST_SEEK && state != ST_ZERO;
	wire        abort_req   = wr_ctl && pwdata[`CTL_ABORT];
	wire        mapped      = paddr == `OFF_CONFIG || paddr == `OFF_CONTROL || paddr == `OFF_STATUS ||
	                          paddr == `OFF_HOME_POS || paddr == `OFF_POSITION;
	wire [7:0]  mode        = config_reg[`CFG_MODE_LSB +: 8];
	wire [5:0]  win         = window_len(config_reg[`CFG_DEB_LSB +: 8]);
	wire        tick        = tick_cnt == 16'(`SAMPLE_CYCLES - 1);
	wire        sample      = switch_raw.home;
	wire [`WINDOW_MAX-1:0] hist_next = {sample_hist[`WINDOW_MAX-2:0], sample};
	wire [5:0]  ones        = count_ones(hist_next, win);
	wire [5:0]  differ      = home_deb ? 6'(win - ones) : ones;
	wire        flip        = sample_fill >= win && {differ, 1'b0} > {1'b0, win};
	wire        next_deb    = (win == 6'h00) ? sample : (flip ? !home_deb : home_deb);
	wire        home_l      = home_deb ^ config_reg[`CFG_INV_HOME];
	wire        next_l      = next_deb ^ config_reg[`CFG_INV_HOME];
	wire        end_a       = switch_raw.end_pos ^ config_reg[`CFG_INV_ENDP];
	wire        end_b       = switch_raw.end_neg ^ config_reg[`CFG_INV_ENDN];
	wire        swap        = config_reg[`CFG_SWAP_END];
	wire        act_pos     = mode == `MODE_19 || mode == `MODE_20;
	wire        rise_mode   = mode == `MODE_20 || mode == `MODE_22;
	// inactive searches toward active side, active searches away
	wire        dir_pos     = act_pos ? !home_l : home_l;
	wire        rise        = tick && next_l && !home_l;
	wire        fall        = tick && !next_l && home_l;
	// edge counted only when reached with travel toward the proper side
	wire        dir_ok      = (rise_mode ? rise : fall) && (rise == (act_pos ? motion.dir_pos : !motion.dir_pos));
	wire        capture     = state == ST_SEEK && dir_ok;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (start_req) next_state = ST_SEEK;
			ST_SEEK: if (capture) next_state = config_reg[`CFG_NO_ZERO_MOVE] ? ST_DONE : ST_ZERO;
			ST_ZERO: if (zero_reached) next_state = ST_DONE;
			ST_DONE: if (start_req) next_state = ST_SEEK;
			default: next_state = ST_IDLE;
		endcase
		if (abort_req)
			next_state = ST_IDLE;
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`OFF_CONFIG:   next_prdata = config_reg;
			`OFF_STATUS:   next_prdata = {24'h00_0000, state, 1'b0, switch_logic};
			`OFF_HOME_POS: next_prdata = home_pos;
			`OFF_POSITION: next_prdata = axis_position;
			default:       next_prdata = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave, one wait-free access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= `CFG_RESET;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			if (wr_cfg)
				config_reg <= pwdata;
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !setup_wr)
				prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sampling tick and majority filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt    <= 16'h0000;
			sample_hist <= '0;
			sample_fill <= 6'h00;
			home_deb    <= 1'b0;
		end else begin
			tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
			if (tick) begin
				sample_hist <= hist_next;
				if (sample_fill < 6'(`WINDOW_MAX))
					sample_fill <= sample_fill + 6'h01;
				home_deb  <= next_deb;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// search sequencer and outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= ST_IDLE;
			home_pos     <= 32'h0000_0000;
			motion       <= '0;
			switch_logic <= '0;
			home_valid   <= 1'b0;
		end else begin
			state <= next_state;
			if (capture)
				home_pos <= axis_position;
			switch_logic <= {home_l, swap ? end_b : end_a, swap ? end_a : end_b};
			if (state != ST_SEEK)
				motion.dir_pos <= dir_pos;
			motion.run          <= next_state == ST_SEEK || next_state == ST_ZERO;
			motion.move_to_zero <= next_state == ST_ZERO;
			motion.limits_off   <= next_state == ST_SEEK || next_state == ST_ZERO;
			if (start_req)
				home_valid <= 1'b0;
			else if (capture)
				home_valid <= 1'b1;
		end
	end
endmodule

/* File: verification/homing_switch_edge_search_properties.sv */
// bus and capture assertions for the homing search block
`timescale 1ns/10ps
`include "homing_cfg.svh"
module homing_checks (
	// clock, reset and apb
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// motion and switch states
	input wire homing_pkg::motion_type motion,
	input wire homing_pkg::switch_type switch_logic,
	input wire logic                   home_valid
);
	import homing_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	access_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	unmapped_error_a: assert property (pready && paddr > `OFF_POSITION |-> pslverr)
		else $error("no error on unmapped");
	mapped_ok_a: assert property (pready && paddr <= `OFF_POSITION && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("error on mapped");
	limits_off_a: assert property (motion.run |-> motion.limits_off)
		else $error("limits watched in run");
	capture_edge_a: assert property ($rose(home_valid) |=> switch_logic.home != $past(switch_logic.home, 2))
		else $error("capture without edge");
	valid_clear_a: assert property ($fell(home_valid) |-> $past(psel && penable && pwrite && paddr == `OFF_CONTROL
		&& pwdata[`CTL_START])) else $error("valid lost without start");
	zero_after_valid_a: assert property ($rose(motion.move_to_zero) |-> ##[0:2] home_valid)
		else $error("zero move before capture");
endmodule
bind homing_switch_edge_search homing_checks u_checks (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .motion, .switch_logic, .home_valid);

/* File: verification/homing_partner.sv */
// switch and axis model at the far side of the homing block
`timescale 1ns/10ps
module homing_partner #(
	parameter int LAG = 200
) (
	// clock, commanded levels and motion
	input  wire logic                   pclk,
	input  wire logic                   home_lvl,
	input  wire logic                   endp_lvl,
	input  wire logic                   endn_lvl,
	input  wire homing_pkg::motion_type motion,
	// switch wires and feedback
	output homing_pkg::switch_type      switch_raw,
	output logic                        zero_reached,
	output logic                        zero_pulse
);
	import homing_pkg::*;
	int cnt = 0;
	int fc = 0;
	assign switch_raw = '{home: home_lvl, end_pos: endp_lvl, end_neg: endn_lvl};
	assign zero_reached = cnt > LAG;
	assign zero_pulse = fc[2];
	always @(posedge pclk) begin
		cnt <= motion.move_to_zero ? cnt + 1 : 0;
		fc <= fc + 1;
	end
endmodule

/* File: verification/homing_switch_edge_search_tb.sv */
// self-checking bench for the homing search block
`timescale 1ns/10ps
`include "homing_cfg.svh"
module homing_switch_edge_search_tb;
	import homing_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, home_lvl = 0, endp_lvl = 0, endn_lvl = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, axis_position = '0, prdata, rd, pos;
	logic        pready, pslverr, zero_pulse, zero_reached, home_valid, err;
	switch_type  switch_raw, switch_logic;
	motion_type  motion;
	int          error_cnt = 0, total_checks = 0;
	always #12.5 pclk = ~pclk;
	homing_switch_edge_search dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .switch_raw, .zero_pulse, .axis_position, .zero_reached, .motion, .switch_logic, .home_valid);
	homing_partner far (.pclk, .home_lvl, .endp_lvl, .endn_lvl, .motion, .switch_raw, .zero_reached,
		.zero_pulse);
	////////////////////////////////////////
	function automatic logic dir_exp(input int m);
		return m < 21;
	endfunction
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic tick();
		repeat (`SAMPLE_CYCLES + 4) @(posedge pclk);
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h22EC));
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, `OFF_CONFIG, 0);
		chk(rd, `CFG_RESET);
		apb(0, `OFF_STATUS, 0);
		chk(rd[7:4], 4'h1);
		pos = 32'h14 + ($urandom % 900) * 4;
		apb(1, pos[11:0], $urandom);
		chk(err, 1);
		apb(0, pos[11:0], 0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		$display("test reset done");
		for (int m = 19; m <= 22; m++) begin
			apb(1, `OFF_CONFIG, m);
			apb(1, `OFF_CONTROL, 32'h1);
			apb(0, `OFF_STATUS, 0);
			chk(rd[7:4], 4'h2);
			chk(motion.dir_pos, dir_exp(m));
			chk(motion.run, 1);
			chk(motion.limits_off, 1);
			apb(1, `OFF_CONTROL, 32'h2);
		end
		$display("test direction done");
		apb(1, `OFF_CONFIG, 32'h0009_0014);
		home_lvl <= 1;
		endp_lvl <= 1;
		tick();
		chk(switch_logic, 3'b001);
		apb(1, `OFF_CONTROL, 32'h1);
		apb(0, `OFF_STATUS, 0);
		chk(motion.dir_pos, 1);
		pos = $urandom;
		axis_position <= pos;
		home_lvl <= 0;
		tick();
		chk(home_valid, 1);
		chk(motion.move_to_zero, 1);
		apb(0, `OFF_HOME_POS, 0);
		chk(rd, pos);
		for (int i = 0; i < 200 && (i == 0 || rd[7:4] !== 4'h8); i++) apb(0, `OFF_STATUS, 0);
		chk(rd[7:4], 4'h8);
		$display("test rising capture done");
		apb(1, `OFF_CONFIG, 32'h0015_0013);
		endn_lvl <= 1;
		apb(1, `OFF_CONTROL, 32'h1);
		apb(0, `OFF_STATUS, 0);
		chk(home_valid, 0);
		chk(motion.dir_pos, 0);
		pos = $urandom;
		axis_position <= pos;
		home_lvl <= 1;
		tick();
		chk(home_valid, 1);
		chk(motion.move_to_zero, 0);
		chk(switch_logic, 3'b010);
		apb(0, `OFF_HOME_POS, 0);
		chk(rd, pos);
		$display("test falling capture done");
		summarize();
	end
endmodule
